// >>> cdh_port.v
// Host port of a two-line, forty-cell character display controller.
// Assumes asynchronous bus pins and a scan client on the same clock.
//
// Function
// - Only a command register and a data register are host visible.
// - Command register is write only; status read replaces it.
// - Written data byte goes to memory at the address counter.
// - Address command prefetches that location into the data register.
// - Each data read reloads the data register from the next address.
// - Select low with a write cycle takes the byte as a command.
// - Select low read drives busy on bit 7, counter on bits 0-6.
// - Select high write fills data register, then the chosen memory.
// - Select high read drives the prefetched data register.
// - While busy, further instructions from the host are ignored.
// - Address command loads the counter and picks display or pattern.
// - Counter steps by one after each data access, up or down.
// - Display memory holds byte codes; unused cells are plain storage.
// - Cells 00H-27H form line one, 40H-67H form line two.
// - Fixed store turns codes into 5x8 patterns, 240 of them.
// - Codes 00H-0FH take patterns from user pattern memory.
// - User memory holds eight 5x8 patterns; spare bits 5-7 are storage.
// - Four-bit mode uses lines 4-7, high nibble first, then low.
// - Code bits 0-2 give pattern address bits 3-5; bit 3 ignored.
// - Reset fills display with spaces, counter zero, eight-bit mode.
`timescale 1ns/1ps
`include "cdh_map.vh"

module cdh_port (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    input wire ce,
    // Bus pins
    input wire strobe_mode,
    input wire register_select,
    input wire rw_wr_n,
    input wire enable_rd_n,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe_n,
    // Scan port
    input wire scan_line,
    input wire [5:0] scan_col,
    input wire [2:0] scan_row,
    output reg [7:0] scan_code,
    output reg [4:0] scan_dots,
    // Status
    output reg busy_flag,
    output reg bus_4bit,
    output reg two_line,
    output reg display_on,
    output reg cursor_on,
    output reg cursor_blink,
    output reg shift_enable,
    output reg [1:0] brightness
);

    // ------------------------------------------------------------------
    // State codes and constants
    // ------------------------------------------------------------------
    localparam [5:0] S_CLEAR = 6'h01;
    localparam [5:0] S_IDLE = 6'h02;
    localparam [5:0] S_WRITE = 6'h04;
    localparam [5:0] S_FETCH = 6'h08;
    localparam [5:0] S_CAPT = 6'h10;
    localparam [5:0] S_EXEC = 6'h20;
    localparam integer EXEC_FULL = `CDH_EXEC_CYCLES;
    localparam [7:0] EXEC_CNT = EXEC_FULL[7:0];

    reg [5:0] state;
    reg [7:0] exec_cnt;
    reg [6:0] clr_addr;
    reg [6:0] memory_address_counter;
    reg [7:0] data_transfer_register;
    reg select_pattern;
    reg count_up;
    reg rw_prev;
    reg en_prev;
    reg nib_lo;
    reg [3:0] nib_hi;

    // ------------------------------------------------------------------
    // Pin synchronisation and strobe decode
    // ------------------------------------------------------------------
    wire [11:0] pin_s;

    cdh_sync #(.WIDTH(12)) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .d({strobe_mode, register_select, rw_wr_n, enable_rd_n, data_in}),
        .q(pin_s)
    );

    wire s_mode = pin_s[11];
    wire s_rs = pin_s[10];
    wire s_rw = pin_s[9];
    wire s_en = pin_s[8];
    wire [7:0] s_data = pin_s[7:0];

    // Level mode ends a cycle on the falling enable; strobe mode on the
    // rising edge of whichever strobe was low.
    wire w_ev = s_mode ? (s_rw & ~rw_prev) : (~s_en & en_prev & ~s_rw);
    wire r_ev = s_mode ? (s_en & ~en_prev) : (~s_en & en_prev & s_rw);
    wire drive = s_mode ? ~s_en : (s_en & s_rw);

    wire busy = (state != S_IDLE);
    wire byte_end = ~bus_4bit | nib_lo;
    wire [7:0] wr_byte = bus_4bit ? {nib_hi, s_data[7:4]} : s_data;
    // Busy is judged at the last transfer of a byte (byte_end).
    wire wr_take = w_ev & byte_end & ~busy;
    wire rd_data = r_ev & byte_end & s_rs & ~busy;
    wire [7:0] status_byte = {busy, memory_address_counter};
    wire [7:0] rd_byte = s_rs ? data_transfer_register : status_byte;

    // ------------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------------
    wire [6:0] a_addr = (state == S_CLEAR) ? clr_addr : memory_address_counter;
    wire [7:0] a_wdata = (state == S_CLEAR) ? `CDH_SPACE_CODE : data_transfer_register;
    wire dd_we = (state == S_CLEAR) | ((state == S_WRITE) & ~select_pattern);
    wire cg_we = (state == S_WRITE) & select_pattern;
    wire [7:0] dd_q;
    wire [7:0] cg_q;
    wire [7:0] cell_code;
    wire [7:0] cg_row;
    reg [2:0] row_d1;
    reg [2:0] row_d2;
    reg [7:0] code_d2;

    // Cells 00H-27H are line one, 40H-67H line two; the rest is storage.
    wire [6:0] cell_addr = scan_line ? (`CDH_LINE2_BASE | {1'b0, scan_col})
                                     : {1'b0, scan_col};

    cdh_ram #(.AW(`CDH_DD_AW), .DW(8)) u_display_memory (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .a_we(dd_we),
        .a_addr(a_addr),
        .a_wdata(a_wdata),
        .a_q(dd_q),
        .b_addr(cell_addr),
        .b_q(cell_code)
    );

    // Code bit 3 is dropped, so 00H and 08H show the same pattern.
    cdh_ram #(.AW(`CDH_CG_AW), .DW(8)) u_user_pattern_memory (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .a_we(cg_we),
        .a_addr(a_addr[5:0]),
        .a_wdata(a_wdata),
        .a_q(cg_q),
        .b_addr({cell_code[2:0], row_d1}),
        .b_q(cg_row)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Pattern addresses wrap inside their 64 bytes.
    function [6:0] step_addr;
        input [6:0] a;
        input up;
        input pat;
        reg [6:0] s;
        begin
            s = up ? (a + 7'h01) : (a - 7'h01);
            step_addr = pat ? {1'b0, s[5:0]} : s;
        end
    endfunction

    // Stand-in glyph table: the real font contents are not held here.
    function [4:0] fixed_row;
        input [7:0] code;
        input [2:0] row;
        begin
            fixed_row = (row == 3'h7) ? 5'h00 : (code[4:0] ^ {row, 2'b00});
        end
    endfunction

    // ------------------------------------------------------------------
    // Host side: output drive and nibble sequencing
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rw_prev <= 1'b0;
            en_prev <= 1'b0;
            nib_lo <= 1'b0;
            nib_hi <= 4'h0;
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
        end else if (ce) begin
            rw_prev <= s_rw;
            en_prev <= s_en;
            data_oe_n <= ~drive;
            if (bus_4bit) begin
                data_out <= nib_lo ? {rd_byte[3:0], 4'h0}
                                   : {rd_byte[7:4], 4'h0};
            end else begin
                data_out <= rd_byte;
            end
            if (!bus_4bit) begin
                nib_lo <= 1'b0;
            end else if (w_ev && (nib_lo || !busy)) begin
                nib_lo <= ~nib_lo;
                nib_hi <= s_data[7:4];
            end else if (r_ev) begin
                nib_lo <= ~nib_lo;
            end
        end
    end

    // ------------------------------------------------------------------
    // Controller sequence
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_CLEAR;
            exec_cnt <= 8'h00;
            clr_addr <= 7'h00;
            memory_address_counter <= `CDH_AC_RESET;
            data_transfer_register <= 8'h00;
            select_pattern <= 1'b0;
            count_up <= 1'b1;
            busy_flag <= 1'b1;
            bus_4bit <= 1'b0;
            two_line <= 1'b1;
            display_on <= 1'b0;
            cursor_on <= 1'b0;
            cursor_blink <= 1'b0;
            shift_enable <= 1'b0;
            brightness <= `CDH_BRIGHT_RESET;
        end else if (ce) begin
            case (state)
                S_CLEAR: begin
                    clr_addr <= clr_addr + 7'h01;
                    if (clr_addr == `CDH_DD_LAST) begin
                        memory_address_counter <= `CDH_AC_RESET;
                        select_pattern <= 1'b0;
                        count_up <= 1'b1;
                        exec_cnt <= EXEC_CNT;
                        state <= S_EXEC;
                    end
                end
                S_IDLE: begin
                    if (wr_take && s_rs) begin
                        data_transfer_register <= wr_byte;
                        busy_flag <= 1'b1;
                        state <= S_WRITE;
                    end else if (wr_take) begin
                        busy_flag <= 1'b1;
                        exec_cnt <= EXEC_CNT;
                        state <= S_EXEC;
                        if (wr_byte[`CDH_DDADDR_BIT]) begin
                            memory_address_counter <= wr_byte[6:0];
                            select_pattern <= 1'b0;
                            state <= S_FETCH;
                        end else if (wr_byte[`CDH_CGADDR_BIT]) begin
                            memory_address_counter <= {1'b0, wr_byte[5:0]};
                            select_pattern <= 1'b1;
                            state <= S_FETCH;
                        end else if (wr_byte[`CDH_FSET_BIT]) begin
                            bus_4bit <= ~wr_byte[`CDH_FSET_IF_BIT];
                            two_line <= wr_byte[`CDH_FSET_N_BIT];
                            brightness <= wr_byte[1:0];
                        end else if (wr_byte[`CDH_SHIFT_BIT]) begin
                            // Display shift has no effect on the scan port.
                            if (!wr_byte[`CDH_SHIFT_SC_BIT]) begin
                                memory_address_counter <= step_addr(
                                    memory_address_counter,
                                    wr_byte[`CDH_SHIFT_RL_BIT], select_pattern);
                            end
                        end else if (wr_byte[`CDH_DISP_BIT]) begin
                            display_on <= wr_byte[`CDH_DISP_D_BIT];
                            cursor_on <= wr_byte[`CDH_DISP_C_BIT];
                            cursor_blink <= wr_byte[`CDH_DISP_B_BIT];
                        end else if (wr_byte[`CDH_ENTRY_BIT]) begin
                            count_up <= wr_byte[`CDH_ENTRY_ID_BIT];
                            shift_enable <= wr_byte[`CDH_ENTRY_S_BIT];
                        end else if (wr_byte[`CDH_HOME_BIT]) begin
                            memory_address_counter <= `CDH_AC_RESET;
                            select_pattern <= 1'b0;
                        end else if (wr_byte[`CDH_CLEAR_BIT]) begin
                            clr_addr <= 7'h00;
                            state <= S_CLEAR;
                        end
                    end else if (rd_data) begin
                        memory_address_counter <= step_addr(
                            memory_address_counter, count_up,
                            select_pattern);
                        busy_flag <= 1'b1;
                        state <= S_FETCH;
                    end
                end
                S_WRITE: begin
                    memory_address_counter <= step_addr(
                        memory_address_counter, count_up,
                        select_pattern);
                    exec_cnt <= EXEC_CNT;
                    state <= S_EXEC;
                end
                S_FETCH: begin
                    state <= S_CAPT;
                end
                S_CAPT: begin
                    data_transfer_register <= select_pattern ? cg_q : dd_q;
                    exec_cnt <= EXEC_CNT;
                    state <= S_EXEC;
                end
                S_EXEC: begin
                    exec_cnt <= exec_cnt - 8'h01;
                    if (exec_cnt <= 8'h01) begin
                        busy_flag <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                    busy_flag <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Scan pipeline: cell code, then pattern row, three cycles in all
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            row_d1 <= 3'h0;
            row_d2 <= 3'h0;
            code_d2 <= 8'h00;
            scan_code <= 8'h00;
            scan_dots <= 5'h00;
        end else if (ce) begin
            row_d1 <= scan_row;
            row_d2 <= row_d1;
            code_d2 <= cell_code;
            scan_code <= code_d2;
            if (code_d2[7:4] == `CDH_USER_CODE_HI) begin
                scan_dots <= cg_row[4:0];
            end else begin
                scan_dots <= fixed_row(code_d2, row_d2);
            end
        end
    end

endmodule // cdh_port

// >>> cdh_map.vh
// Shared constants for the character display host port.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef CDH_MAP_VH
`define CDH_MAP_VH

// ----------------------------------------------------------------------
// Command decode: the highest set bit of a command byte picks its kind
// ----------------------------------------------------------------------
`define CDH_DDADDR_BIT 7
`define CDH_CGADDR_BIT 6
`define CDH_FSET_BIT 5
`define CDH_SHIFT_BIT 4
`define CDH_DISP_BIT 3
`define CDH_ENTRY_BIT 2
`define CDH_HOME_BIT 1
`define CDH_CLEAR_BIT 0

// ----------------------------------------------------------------------
// Field positions inside commands
// ----------------------------------------------------------------------
`define CDH_FSET_IF_BIT 4
`define CDH_FSET_N_BIT 3
`define CDH_SHIFT_SC_BIT 3
`define CDH_SHIFT_RL_BIT 2
`define CDH_DISP_D_BIT 2
`define CDH_DISP_C_BIT 1
`define CDH_DISP_B_BIT 0
`define CDH_ENTRY_ID_BIT 1
`define CDH_ENTRY_S_BIT 0

// ----------------------------------------------------------------------
// Memory layout and reset values
// ----------------------------------------------------------------------
`define CDH_DD_AW 7
`define CDH_CG_AW 6
`define CDH_SPACE_CODE 8'h20
`define CDH_AC_RESET 7'h00
`define CDH_LINE2_BASE 7'h40
`define CDH_DD_LAST 7'h7f
`define CDH_USER_CODE_HI 4'h0
`define CDH_BRIGHT_RESET 2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CDH_CLK_NS 10
`define CDH_EXEC_NS 2000
`define CDH_EXEC_CYCLES ((`CDH_EXEC_NS + `CDH_CLK_NS - 1) / `CDH_CLK_NS)

`endif

// >>> cdh_sync.v
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent level; only the second stage is read.
`timescale 1ns/1ps

module cdh_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    input wire ce,
    // Levels
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);

    reg [WIDTH-1:0] meta;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // cdh_sync

// >>> cdh_ram.v
// Memory with one read-write port and one read-only port, both registered.
// Assumes a single clock; the array itself carries no reset.
`timescale 1ns/1ps

module cdh_ram #(
    parameter AW = 7,
    parameter DW = 8
) (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    input wire ce,
    // Read-write port
    input wire a_we,
    input wire [AW-1:0] a_addr,
    input wire [DW-1:0] a_wdata,
    output reg [DW-1:0] a_q,
    // Read-only port
    input wire [AW-1:0] b_addr,
    output reg [DW-1:0] b_q
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clock) begin
        if (ce && a_we) begin
            mem[a_addr] <= a_wdata;
        end
    end

    // Reads return the old word when port A writes the same location.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            a_q <= {DW{1'b0}};
            b_q <= {DW{1'b0}};
        end else if (ce) begin
            a_q <= mem[a_addr];
            b_q <= mem[b_addr];
        end
    end

endmodule // cdh_ram

// >>> cdh_port_chk_sva.sv
// Checker for the host port: bus drive timing and busy behaviour.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module cdh_port_chk (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Bus
    input wire strobe_mode,
    input wire register_select,
    input wire rw_wr_n,
    input wire enable_rd_n,
    input wire [7:0] data_out,
    input wire data_oe_n,
    // Status
    input wire busy_flag,
    input wire bus_4bit,
    input wire two_line,
    input wire [1:0] brightness
);
    wire rd_act = strobe_mode ? !enable_rd_n : enable_rd_n && rw_wr_n;
    reg [9:0] busy_cnt;
    // Saturates so a stuck busy flag cannot wrap into a legal length.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            busy_cnt <= 10'h000;
        else if (!busy_flag)
            busy_cnt <= 10'h000;
        else if (busy_cnt != 10'h3ff)
            busy_cnt <= busy_cnt + 10'h001;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    oe_drive_a: assert property (((!strobe_mode && rw_wr_n &&
        $rose(enable_rd_n)) || (strobe_mode && $fell(enable_rd_n)))
        |-> ##[2:4] !data_oe_n) else $error("read not driven");
    oe_release_a: assert property (((!strobe_mode &&
        $fell(enable_rd_n)) || (strobe_mode && $rose(enable_rd_n)))
        |-> ##[2:4] data_oe_n) else $error("bus not released");
    oe_cause_a: assert property (!data_oe_n |->
        $past(rd_act, 3) || $past(rd_act, 4))
        else $error("drive without read");
    drive_hold_a: assert property (!data_oe_n && rd_act |=>
        !data_oe_n) else $error("drive dropped in read");
    status_bit_a: assert property (!data_oe_n && !register_select &&
        $past(!register_select, 5) && !bus_4bit &&
        busy_flag == $past(busy_flag, 3) |-> data_out[7] == busy_flag)
        else $error("status bit 7 not busy");
    busy_rise_a: assert property (!busy_flag && !bus_4bit &&
        ((!strobe_mode && !rw_wr_n && $fell(enable_rd_n)) ||
        (strobe_mode && $rose(rw_wr_n))) |-> ##[2:5] busy_flag)
        else $error("write did not start work");
    busy_len_a: assert property ($fell(busy_flag) |->
        busy_cnt >= 10'h0c6 && busy_cnt <= 10'h190)
        else $error("busy length wrong");
    cfg_change_a: assert property (($changed(bus_4bit) ||
        $changed(two_line) || $changed(brightness)) |->
        busy_flag) else $error("setting changed while idle");
endmodule // cdh_port_chk

bind cdh_port cdh_port_chk i_chk (.clock(clock), .rst_b(rst_b),
    .strobe_mode(strobe_mode), .register_select(register_select),
    .rw_wr_n(rw_wr_n), .enable_rd_n(enable_rd_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .busy_flag(busy_flag), .bus_4bit(bus_4bit),
    .two_line(two_line), .brightness(brightness));

// >>> cdh_host.sv
// Host processor model driving the display port bus pins.
// Assumes the port clock; mode changes only while the port is in reset.
`timescale 1ns/1ps
module cdh_host (
    // Clock
    input wire clock,
    // Bus pins
    input wire [7:0] data_out,
    output reg strobe_mode,
    output reg register_select,
    output reg rw_wr_n,
    output reg enable_rd_n,
    output reg [7:0] data_in
);
    reg nib4;
    initial begin
        strobe_mode = 1'b0;
        register_select = 1'b0;
        rw_wr_n = 1'b1;
        enable_rd_n = 1'b0;
        data_in = 8'h00;
        nib4 = 1'b0;
    end
    task set_mode(input m);
        begin
            strobe_mode <= m;
            enable_rd_n <= m;
        end
    endtask
    // Pins are held well past the two-flop sampling delay.
    task pin_cycle(input rs, input rd, input [7:0] din, output [7:0] q);
        begin
            @(posedge clock);
            register_select <= rs;
            data_in <= rd ? ~data_in : din;
            if (strobe_mode) begin
                if (rd)
                    enable_rd_n <= 1'b0;
                else
                    rw_wr_n <= 1'b0;
            end else begin
                rw_wr_n <= rd;
                enable_rd_n <= 1'b1;
            end
            repeat (5) @(posedge clock);
            @(negedge clock);
            q = data_out;
            @(posedge clock);
            enable_rd_n <= strobe_mode;
            rw_wr_n <= strobe_mode | rw_wr_n;
            repeat (5) @(posedge clock);
            data_in <= ~data_in;
        end
    endtask
    task xfer(input rs, input rd, input [7:0] din, output [7:0] q);
        reg [7:0] hi;
        reg [7:0] lo;
        begin
            if (nib4) begin
                pin_cycle(rs, rd, {din[7:4], 4'h0}, hi);
                pin_cycle(rs, rd, {din[3:0], 4'h0}, lo);
                q = {hi[7:4], lo[7:4]};
            end else begin
                pin_cycle(rs, rd, din, q);
            end
        end
    endtask
    // Bounded, so a stuck busy flag surfaces as a wrong status byte.
    task poll(output [7:0] st);
        integer n;
        begin
            st = 8'hff;
            for (n = 0; n < 60 && st[7] !== 1'b0; n = n + 1)
                xfer(1'b0, 1'b1, 8'h00, st);
        end
    endtask
endmodule // cdh_host

// >>> testbench.sv
// Self-checking bench for the host port against a memory model.
// Assumes the host model drives the pins; scan inputs come from here.
`timescale 1ns/1ps
module testbench;
    reg clock = 1'b0;
    reg rst_b = 1'b0;
    reg scan_line = 1'b0;
    reg [5:0] scan_col = 6'h00;
    reg [2:0] scan_row = 3'h0;
    wire strobe_mode, register_select, rw_wr_n, enable_rd_n;
    wire data_oe_n, busy_flag, bus_4bit, display_on, cursor_on, cursor_blink;
    wire [7:0] data_in, data_out, scan_code;
    wire [4:0] scan_dots;
    integer err_total = 0;
    integer tests_run = 0;
    integer i;
    reg [7:0] dd [0:127];
    reg [7:0] cg [0:63];
    reg [6:0] ac;
    reg sel, up;
    reg [7:0] v;
    reg [5:0] c;
    always #5 clock = ~clock;
    cdh_host i_host (.clock(clock), .data_out(data_out),
        .strobe_mode(strobe_mode), .register_select(register_select),
        .rw_wr_n(rw_wr_n), .enable_rd_n(enable_rd_n), .data_in(data_in));
    cdh_port i_dut (.clock(clock), .rst_b(rst_b), .ce(1'b1),
        .strobe_mode(strobe_mode), .register_select(register_select),
        .rw_wr_n(rw_wr_n), .enable_rd_n(enable_rd_n), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .scan_line(scan_line),
        .scan_col(scan_col), .scan_row(scan_row), .scan_code(scan_code),
        .scan_dots(scan_dots), .busy_flag(busy_flag), .bus_4bit(bus_4bit),
        .two_line(), .display_on(display_on), .cursor_on(cursor_on),
        .cursor_blink(cursor_blink), .shift_enable(), .brightness());
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("Error at %0t: saw %h, expected %h", $time, seen,
                    exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("Checks %0d, errors %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task do_reset(input m);
        begin
            @(posedge clock);
            rst_b <= 1'b0;
            i_host.set_mode(m);
            repeat (2) @(posedge clock);
            chk({6'h00, busy_flag, data_oe_n}, 8'h03);
            repeat (6) @(posedge clock);
            rst_b <= 1'b1;
            for (i = 0; i < 128; i = i + 1)
                dd[i] = 8'h20;
            ac = 7'h00;
            sel = 1'b0;
            up = 1'b1;
        end
    endtask
    task step;
        begin
            ac = up ? ac + 7'h01 : ac - 7'h01;
            if (sel)
                ac[6] = 1'b0;
        end
    endtask
    task cmd(input [7:0] b);
        begin
            i_host.poll(v);
            i_host.xfer(1'b0, 1'b0, b, v);
            if (b[7]) begin
                ac = b[6:0];
                sel = 1'b0;
            end else if (b[6]) begin
                ac = {1'b0, b[5:0]};
                sel = 1'b1;
            end else if (b[7:2] == 6'h01) begin
                up = b[1];
            end else if (b[7:5] == 3'h1) begin
                i_host.nib4 = !b[4];
            end
        end
    endtask
    task wr(input [7:0] d);
        begin
            i_host.poll(v);
            i_host.xfer(1'b1, 1'b0, d, v);
            if (sel)
                cg[ac[5:0]] = d;
            else
                dd[ac] = d;
            step;
        end
    endtask
    task rd;
        begin
            i_host.poll(v);
            i_host.xfer(1'b1, 1'b1, 8'h00, v);
            chk(v, sel ? cg[ac[5:0]] : dd[ac]);
            step;
        end
    endtask
    task stat;
        begin
            i_host.poll(v);
            chk(v, {1'b0, ac});
        end
    endtask
    task look(input l, input [5:0] cc, input [2:0] r);
        begin
            @(posedge clock);
            scan_line <= l;
            scan_col <= cc;
            scan_row <= r;
            repeat (4) @(posedge clock);
        end
    endtask
    initial begin
        #600_000;
        err_total = err_total + 1;
        close_out;
    end
    initial begin
        void'($urandom(55241));
        do_reset(1'b0);
        stat;
        chk({7'h00, bus_4bit}, 8'h00);
        cmd(8'ha6);
        for (i = 0; i < 5; i = i + 1)
            wr(8'($urandom));
        cmd(8'ha6);
        for (i = 0; i < 7; i = i + 1)
            rd;
        stat;
        cmd(8'h04);
        cmd(8'hc0);
        wr(8'($urandom));
        wr(8'($urandom));
        stat;
        cmd(8'h06);
        i_host.poll(v);
        i_host.xfer(1'b0, 1'b0, 8'h85, v);
        i_host.xfer(1'b0, 1'b0, 8'h90, v);
        ac = 7'h05;
        stat;
        cmd(8'h48);
        for (i = 0; i < 8; i = i + 1)
            wr(8'($urandom));
        cmd(8'h48);
        for (i = 0; i < 8; i = i + 1)
            rd;
        cmd(8'hc0);
        wr(8'h09);
        for (i = 0; i < 8; i = i + 1) begin
            look(1'b1, 6'h00, i[2:0]);
            chk(scan_code, 8'h09);
            chk({3'h0, scan_dots}, {3'h0, cg[8 + i][4:0]});
        end
        for (i = 0; i < 6; i = i + 1) begin
            c = 6'($urandom % 40);
            v[0] = $urandom % 2;
            look(v[0], c, 3'h0);
            chk(scan_code, dd[{v[0], c}]);
        end
        cmd(8'h0e);
        chk({5'h00, display_on, cursor_on, cursor_blink}, 8'h06);
        cmd(8'h01);
        for (i = 0; i < 128; i = i + 1)
            dd[i] = 8'h20;
        cmd(8'ha6);
        rd;
        cmd(8'h28);
        chk({7'h00, bus_4bit}, 8'h01);
        cmd(8'h90);
        wr(8'($urandom));
        wr(8'($urandom));
        cmd(8'h90);
        rd;
        rd;
        stat;
        cmd(8'h38);
        i_host.poll(v);
        chk({7'h00, bus_4bit}, 8'h00);
        do_reset(1'b1);
        stat;
        cmd(8'ha0);
        for (i = 0; i < 3; i = i + 1)
            wr(8'($urandom));
        cmd(8'ha0);
        for (i = 0; i < 3; i = i + 1)
            rd;
        stat;
        close_out;
    end
endmodule // testbench
